// file: hw/itp_fifo.sv
`timescale 1ns/1ns
// ****************************************
// Request FIFO
// ****************************************
module itp_fifo #(
   parameter int WIDTH = 35,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_param_chk
      $error("itp_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [PTR_W:0] count_ff;
   logic push;
   logic pop;

   assign in_ready = (count_ff != (PTR_W+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = mem_ff[rd_ptr_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule // itp_fifo

// file: hw/itp_pkg.sv
// ****************************************
// Table port constants
// ****************************************
package itp_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int CFG_ADDR_W = 7;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int TADDR_W = 14;
   localparam int SEL_W = 4;
   localparam int CODE_W = 2;
   localparam int HI_ADDR_W = 6;
   localparam int FIFO_DEPTH = 8;
   localparam int REQ_W = 1 + CODE_W + CODE_W + TADDR_W + WORD_W;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [CFG_ADDR_W-1:0] REG_SELECT = 7'h03;
   localparam logic [CFG_ADDR_W-1:0] REG_ADDR_HI = 7'h04;
   localparam logic [CFG_ADDR_W-1:0] REG_ADDR_LO = 7'h05;
   localparam logic [CFG_ADDR_W-1:0] REG_DATA = 7'h06;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int SEL_TYPE_LSB = 0;
   localparam int SEL_COL_LSB = 2;
   localparam int DIR_BIT = 6;
   localparam int LO_ADDR_W = 8;

   // ****************************************
   // Codes
   // ****************************************
   localparam logic [CODE_W-1:0] TYPE_OFFSET = 2'h0;
   localparam logic [CODE_W-1:0] TYPE_GAIN = 2'h1;
   localparam logic [CODE_W-1:0] TYPE_GAMMA = 2'h2;
   localparam logic [CODE_W-1:0] TYPE_UNDEF = 2'h3;
   localparam logic [CODE_W-1:0] COL_RED = 2'h0;
   localparam logic [CODE_W-1:0] COL_GREEN = 2'h1;
   localparam logic [CODE_W-1:0] COL_BLUE = 2'h2;
   localparam logic [CODE_W-1:0] COL_UNDEF = 2'h3;

   // ****************************************
   // Limits and reset values
   // ****************************************
   localparam logic [TADDR_W-1:0] GAMMA_LAST = 14'h0ffd;
   localparam logic [TADDR_W-1:0] COEF_LAST = 14'h3fff;
   localparam logic [WORD_W-1:0] GAMMA_MASK = 16'h0fff;
   localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
   localparam logic [TADDR_W-1:0] ADDR_RST = 14'h0000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

   // ****************************************
   // Prefetch states
   // ****************************************
   typedef enum logic [1:0] {
      ITP_PF_IDLE = 2'b00,
      ITP_PF_ISSUE = 2'b01,
      ITP_PF_WAIT = 2'b10,
      ITP_PF_READY = 2'b11
   } itp_pf_state_t;
endpackage

// file: hw/itp_table_port.sv
`timescale 1ns/1ns
// Operation
// - Select register bits 1:0 pick table: offset, gain, gamma; code 3 undefined.
// - Select register bits 3:2 pick colour: red, green, blue; code 3 undefined.
// - Fourteen-bit word address: high bits at register 4, low byte at 5.
// - Bit 6 of register 4 sets direction; read direction starts a prefetch.
// - Word address advances by one after each complete two-byte word.
// - Gamma addresses run 0 to 4093 and then wrap to 0.
// - Gain and offset addresses run 0 to 16383 and then wrap to 0.
// - Eight-bit data register at 6 moves sequential bytes of the table.
// - Coefficient words: first byte bits 15:8, second byte bits 7:0.
// - Gamma words: first byte four zeros over bits 11:8, second bits 7:0.
// - Host writes a register address once, then any number of data accesses.
// - Port registers 3 to 6 take writes while idle, no soft reset needed.
module itp_table_port #(
   parameter int FIFO_DEPTH = itp_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Configuration register protocol
   input wire logic cfg_addr_we,
   input wire logic [itp_pkg::CFG_ADDR_W-1:0] cfg_addr,
   input wire logic cfg_data_we,
   input wire logic [itp_pkg::BYTE_W-1:0] cfg_wdata,
   input wire logic cfg_data_re,
   output logic cfg_ready,
   output logic cfg_rvalid,
   output logic [itp_pkg::BYTE_W-1:0] cfg_rdata,
   // Table memory requests
   output logic mem_req_valid,
   input wire logic mem_req_ready,
   output logic mem_req_write,
   output logic [itp_pkg::CODE_W-1:0] mem_req_type,
   output logic [itp_pkg::CODE_W-1:0] mem_req_colour,
   output logic [itp_pkg::TADDR_W-1:0] mem_req_addr,
   output logic [itp_pkg::WORD_W-1:0] mem_req_wdata,
   // Table memory read answers
   input wire logic mem_rsp_valid,
   input wire logic [itp_pkg::WORD_W-1:0] mem_rsp_data
);
   if (FIFO_DEPTH < 2) begin : g_depth_chk
      $error("itp_table_port: FIFO_DEPTH must be at least 2");
   end

   // ****************************************
   // Functions
   // ****************************************
   function automatic logic [itp_pkg::TADDR_W-1:0] next_addr(
      input logic [itp_pkg::TADDR_W-1:0] cur,
      input logic gamma
   );
      logic [itp_pkg::TADDR_W-1:0] last;
      last = gamma ? itp_pkg::GAMMA_LAST : itp_pkg::COEF_LAST;
      if (cur >= last) begin
         next_addr = itp_pkg::ADDR_RST;
      end else begin
         next_addr = cur + 1'b1;
      end
   endfunction

   function automatic logic [itp_pkg::WORD_W-1:0] fmt_word(
      input logic [itp_pkg::WORD_W-1:0] raw,
      input logic gamma
   );
      fmt_word = gamma ? (raw & itp_pkg::GAMMA_MASK) : raw;
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   logic [itp_pkg::CFG_ADDR_W-1:0] cfg_ptr_ff;
   logic [itp_pkg::SEL_W-1:0] sel_ff;
   logic dir_ff;
   logic [itp_pkg::TADDR_W-1:0] addr_ff;
   logic byte_ph_ff;
   logic [itp_pkg::BYTE_W-1:0] hi_byte_ff;
   itp_pkg::itp_pf_state_t pf_state_ff;
   itp_pkg::itp_pf_state_t nxt_pf_state;
   logic pf_stale_ff;
   logic [itp_pkg::WORD_W-1:0] pf_word_ff;
   logic rd_pend_ff;
   logic cfg_rvalid_ff;
   logic [itp_pkg::BYTE_W-1:0] cfg_rdata_ff;
   logic [itp_pkg::BYTE_W-1:0] nxt_rdata;
   logic [itp_pkg::CODE_W-1:0] sel_type;
   logic [itp_pkg::CODE_W-1:0] sel_col;
   logic sel_ok;
   logic is_gamma;
   logic wr_take;
   logic rd_take;
   logic wr_sel;
   logic wr_hi;
   logic wr_lo;
   logic port_wr;
   logic commit;
   logic port_rd;
   logic rd_serve;
   logic consume;
   logic restart;
   logic pf_want;
   logic push_rd;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [itp_pkg::REQ_W-1:0] fifo_in_data;
   logic [itp_pkg::REQ_W-1:0] fifo_out_data;
   logic [itp_pkg::WORD_W-1:0] cur_word;
   logic [itp_pkg::WORD_W-1:0] wr_word;
   logic [itp_pkg::TADDR_W-1:0] req_addr;

   // ****************************************
   // Decode
   // ****************************************
   assign sel_type = sel_ff[itp_pkg::SEL_TYPE_LSB +: itp_pkg::CODE_W];
   assign sel_col = sel_ff[itp_pkg::SEL_COL_LSB +: itp_pkg::CODE_W];
   assign sel_ok = (sel_type != itp_pkg::TYPE_UNDEF) && (sel_col != itp_pkg::COL_UNDEF);
   assign is_gamma = (sel_type == itp_pkg::TYPE_GAMMA);

   assign cfg_ready = !rd_pend_ff && fifo_in_ready;
   assign wr_take = cfg_data_we && cfg_ready;
   assign rd_take = cfg_data_re && cfg_ready;

   // Writes to 3..6 accepted only while cfg_ready: no read pending and request FIFO not full
   assign wr_sel = wr_take && (cfg_ptr_ff == itp_pkg::REG_SELECT);
   assign wr_hi = wr_take && (cfg_ptr_ff == itp_pkg::REG_ADDR_HI);
   assign wr_lo = wr_take && (cfg_ptr_ff == itp_pkg::REG_ADDR_LO);
   assign port_wr = wr_take && (cfg_ptr_ff == itp_pkg::REG_DATA) && sel_ok && !dir_ff;
   assign commit = port_wr && byte_ph_ff;

   assign port_rd = rd_take && (cfg_ptr_ff == itp_pkg::REG_DATA) && sel_ok && dir_ff;
   assign rd_serve = (port_rd || rd_pend_ff) && (pf_state_ff == itp_pkg::ITP_PF_READY);
   assign consume = rd_serve && byte_ph_ff;

   assign restart = wr_sel || wr_hi || wr_lo || consume;
   assign pf_want = dir_ff && sel_ok;
   assign push_rd = (pf_state_ff == itp_pkg::ITP_PF_ISSUE) && pf_want && !commit;

   assign cur_word = fmt_word(pf_word_ff, is_gamma);
   assign wr_word = fmt_word({hi_byte_ff, cfg_wdata}, is_gamma);

   // ****************************************
   // Register address pointer
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_ptr_ff <= '0;
      end else if (cfg_addr_we) begin
         cfg_ptr_ff <= cfg_addr;
      end
   end

   // ****************************************
   // Select and direction
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_ff <= itp_pkg::SEL_RST;
      end else if (wr_sel) begin
         sel_ff <= cfg_wdata[itp_pkg::SEL_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dir_ff <= 1'b0;
      end else if (wr_hi) begin
         dir_ff <= cfg_wdata[itp_pkg::DIR_BIT];
      end
   end

   // ****************************************
   // Word address counter
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_ff <= itp_pkg::ADDR_RST;
      end else if (wr_hi) begin
         addr_ff[itp_pkg::TADDR_W-1:itp_pkg::LO_ADDR_W] <= cfg_wdata[itp_pkg::HI_ADDR_W-1:0];
      end else if (wr_lo) begin
         addr_ff[itp_pkg::LO_ADDR_W-1:0] <= cfg_wdata;
      end else if (commit || consume) begin
         addr_ff <= next_addr(addr_ff, is_gamma);
      end
   end

   // ****************************************
   // Byte phase and held first byte
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         byte_ph_ff <= 1'b0;
      end else if (wr_sel || wr_hi || wr_lo) begin
         byte_ph_ff <= 1'b0;
      end else if (port_wr || rd_serve) begin
         byte_ph_ff <= !byte_ph_ff;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hi_byte_ff <= itp_pkg::BYTE_ZERO;
      end else if (port_wr && !byte_ph_ff) begin
         hi_byte_ff <= cfg_wdata;
      end
   end

   // ****************************************
   // Prefetch sequencer
   // ****************************************
   always_comb begin
      nxt_pf_state = pf_state_ff;
      case (pf_state_ff)
         itp_pkg::ITP_PF_IDLE: begin
            if (restart) begin
               nxt_pf_state = itp_pkg::ITP_PF_ISSUE;
            end
         end
         itp_pkg::ITP_PF_ISSUE: begin
            if (!pf_want) begin
               nxt_pf_state = itp_pkg::ITP_PF_IDLE;
            end else if (push_rd && fifo_in_ready) begin
               nxt_pf_state = itp_pkg::ITP_PF_WAIT;
            end
         end
         itp_pkg::ITP_PF_WAIT: begin
            if (mem_rsp_valid) begin
               if (pf_stale_ff || restart) begin
                  nxt_pf_state = itp_pkg::ITP_PF_ISSUE;
               end else begin
                  nxt_pf_state = itp_pkg::ITP_PF_READY;
               end
            end
         end
         itp_pkg::ITP_PF_READY: begin
            if (restart) begin
               nxt_pf_state = itp_pkg::ITP_PF_ISSUE;
            end
         end
         default: begin
            nxt_pf_state = itp_pkg::ITP_PF_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pf_state_ff <= itp_pkg::ITP_PF_IDLE;
      end else begin
         pf_state_ff <= nxt_pf_state;
      end
   end

   // Answer to a read that was issued before the address changed is dropped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pf_stale_ff <= 1'b0;
      end else if (pf_state_ff == itp_pkg::ITP_PF_WAIT && mem_rsp_valid) begin
         pf_stale_ff <= 1'b0;
      end else if (restart && (pf_state_ff == itp_pkg::ITP_PF_WAIT || (push_rd && fifo_in_ready))) begin
         pf_stale_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pf_word_ff <= itp_pkg::WORD_ZERO;
      end else if (pf_state_ff == itp_pkg::ITP_PF_WAIT && mem_rsp_valid) begin
         pf_word_ff <= mem_rsp_data;
      end
   end

   // ****************************************
   // Read answers
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_pend_ff <= 1'b0;
      end else if (rd_serve) begin
         rd_pend_ff <= 1'b0;
      end else if (port_rd) begin
         rd_pend_ff <= 1'b1;
      end
   end

   always_comb begin
      nxt_rdata = itp_pkg::BYTE_ZERO;
      case (cfg_ptr_ff)
         itp_pkg::REG_SELECT: begin
            nxt_rdata = {{(itp_pkg::BYTE_W-itp_pkg::SEL_W){1'b0}}, sel_ff};
         end
         itp_pkg::REG_ADDR_HI: begin
            nxt_rdata = {1'b0, dir_ff, addr_ff[itp_pkg::TADDR_W-1:itp_pkg::LO_ADDR_W]};
         end
         itp_pkg::REG_ADDR_LO: begin
            nxt_rdata = addr_ff[itp_pkg::LO_ADDR_W-1:0];
         end
         itp_pkg::REG_DATA: begin
            if (rd_serve) begin
               nxt_rdata = byte_ph_ff ? cur_word[itp_pkg::BYTE_W-1:0] :
                  cur_word[itp_pkg::WORD_W-1:itp_pkg::BYTE_W];
            end else begin
               nxt_rdata = itp_pkg::BYTE_ZERO;
            end
         end
         default: begin
            nxt_rdata = itp_pkg::BYTE_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rvalid_ff <= 1'b0;
         cfg_rdata_ff <= itp_pkg::BYTE_ZERO;
      end else begin
         cfg_rvalid_ff <= (rd_take && !port_rd) || rd_serve;
         if ((rd_take && !port_rd) || rd_serve) begin
            cfg_rdata_ff <= nxt_rdata;
         end
      end
   end

   assign cfg_rvalid = cfg_rvalid_ff;
   assign cfg_rdata = cfg_rdata_ff;

   // ****************************************
   // Request FIFO towards table memory
   // ****************************************
   // Gamma address past the top of its table goes to entry 0
   assign req_addr = (is_gamma && (addr_ff > itp_pkg::GAMMA_LAST)) ? itp_pkg::ADDR_RST : addr_ff;
   assign fifo_in_valid = commit || push_rd;
   assign fifo_in_data = commit ?
      {1'b1, sel_type, sel_col, req_addr, wr_word} :
      {1'b0, sel_type, sel_col, req_addr, itp_pkg::WORD_ZERO};

   itp_fifo #(
      .WIDTH(itp_pkg::REQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_req_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(mem_req_valid),
      .out_ready(mem_req_ready),
      .out_data(fifo_out_data)
   );

   assign mem_req_write = fifo_out_data[itp_pkg::REQ_W-1];
   assign mem_req_type = fifo_out_data[itp_pkg::REQ_W-2 -: itp_pkg::CODE_W];
   assign mem_req_colour = fifo_out_data[itp_pkg::REQ_W-2-itp_pkg::CODE_W -: itp_pkg::CODE_W];
   assign mem_req_addr = fifo_out_data[itp_pkg::WORD_W +: itp_pkg::TADDR_W];
   assign mem_req_wdata = fifo_out_data[itp_pkg::WORD_W-1:0];
endmodule // itp_table_port

// file: sim/indexed_table_port_tb_top.sv
`timescale 1ns/1ns
module indexed_table_port_tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cfg_addr_we = 1'b0;
   logic [6:0] cfg_addr = 7'h00;
   logic cfg_data_we = 1'b0;
   logic [7:0] cfg_wdata = 8'h00;
   logic cfg_data_re = 1'b0;
   logic cfg_ready, cfg_rvalid, mem_req_valid, mem_req_ready, mem_req_write, mem_rsp_valid;
   logic [7:0] cfg_rdata;
   logic [1:0] mem_req_type, mem_req_colour;
   logic [13:0] mem_req_addr;
   logic [15:0] mem_req_wdata, mem_rsp_data;
   logic stall = 1'b0;
   logic [3:0] delay = 4'h0;
   logic [31:0] rnd = 32'h0000_6332;
   int num_errors = 0;
   int tests_run = 0;
   int hold = 0;
   int lowseen = 0;
   // ****
   // Bench model
   // ****
   logic [3:0] sel = 4'h0;
   logic [13:0] adr = 14'h0000;
   logic dir = 1'b0;
   logic ph = 1'b0;
   logic [7:0] hi = 8'h00;
   logic [6:0] ptr = 7'h00;
   logic [15:0] ref_mem [bit [17:0]];
   logic [34:0] exp_q [$];
   logic good;
   assign good = sel[1:0] != 2'h3 && sel[3:2] != 2'h3;
   itp_table_port DUT (.clk, .rstn, .cfg_addr_we, .cfg_addr, .cfg_data_we, .cfg_wdata, .cfg_data_re, .cfg_ready,
      .cfg_rvalid, .cfg_rdata, .mem_req_valid, .mem_req_ready, .mem_req_write, .mem_req_type, .mem_req_colour,
      .mem_req_addr, .mem_req_wdata, .mem_rsp_valid, .mem_rsp_data);
   itp_mem_model mem (.clk, .rstn, .mem_req_valid, .mem_req_ready, .mem_req_write, .mem_req_type, .mem_req_colour,
      .mem_req_addr, .mem_req_wdata, .stall, .delay, .mem_rsp_valid, .mem_rsp_data);
   always #5 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [13:0] nxt_adr(input logic [13:0] a);
      if (sel[1:0] == 2'h2 && a >= 14'h0ffd) return 14'h0000;
      return a + 14'h0001;
   endfunction
   always @(posedge clk) begin
      rnd <= lfsr(rnd);
      stall <= hold > 0 || rnd[1:0] == 2'h0;
      delay <= rnd[7:4];
      if (hold > 0) hold <= hold - 1;
      if (cfg_data_we && cfg_ready !== 1'b1) lowseen <= lowseen + 1;
      if (mem_req_valid && mem_req_ready && mem_req_write) begin
         check({1'b1, mem_req_type, mem_req_colour, mem_req_addr, mem_req_wdata},
            exp_q.size() > 0 ? exp_q.pop_front() : 35'h7_ffff_ffff);
      end
   end
   // ****
   // Tasks
   // ****
   task automatic check(input logic [34:0] seen, input logic [34:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic point(input logic [6:0] a);
      cfg_addr_we <= 1'b1;
      cfg_data_we <= 1'b0;
      cfg_data_re <= 1'b0;
      cfg_addr <= a;
      ptr = a;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] d);
      int n = 0;
      logic [15:0] w;
      cfg_addr_we <= 1'b0;
      cfg_data_we <= 1'b1;
      cfg_data_re <= 1'b0;
      cfg_wdata <= d;
      do @(posedge clk); while (cfg_ready !== 1'b1 && n++ < 500);
      if (ptr == 7'h03) sel = d[3:0];
      if (ptr == 7'h04) adr[13:8] = d[5:0];
      if (ptr == 7'h04) dir = d[6];
      if (ptr == 7'h05) adr[7:0] = d;
      if (ptr inside {[7'h03:7'h05]}) ph = 1'b0;
      if (ptr == 7'h06 && good && !dir) begin
         if (ph) begin
            w = {(sel[1:0] == 2'h2) ? 4'h0 : hi[7:4], hi[3:0], d};
            exp_q.push_back({1'b1, sel[1:0], sel[3:2], adr, w});
            ref_mem[{sel, adr}] = w;
            adr = nxt_adr(adr);
         end
         hi = d;
         ph = !ph;
      end
   endtask
   task automatic rd();
      int n = 0;
      logic [7:0] e = 8'h00;
      logic [15:0] w;
      cfg_addr_we <= 1'b0;
      cfg_data_we <= 1'b0;
      cfg_data_re <= 1'b1;
      do @(posedge clk); while (cfg_ready !== 1'b1 && n++ < 500);
      cfg_data_re <= 1'b0;
      do @(posedge clk); while (cfg_rvalid !== 1'b1 && n++ < 500);
      if (ptr == 7'h03) e = {4'h0, sel};
      if (ptr == 7'h04) e = {1'b0, dir, adr[13:8]};
      if (ptr == 7'h05) e = adr[7:0];
      if (ptr == 7'h06 && good && dir) begin
         w = ref_mem.exists({sel, adr}) ? ref_mem[{sel, adr}] : 16'h0000;
         e = ph ? w[7:0] : w[15:8];
         if (ph) adr = nxt_adr(adr);
         ph = !ph;
      end
      check({27'h000_0000, cfg_rdata}, {27'h000_0000, e});
   endtask
   task automatic setup(input logic [3:0] s, input logic [13:0] a, input logic d);
      point(7'h03);
      wr({4'h0, s});
      point(7'h04);
      wr({1'b0, d, a[13:8]});
      point(7'h05);
      wr(a[7:0]);
      point(7'h06);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   initial begin
      #200000;
      num_errors++;
      finish_test();
   end
   initial begin
      logic [3:0] s;
      logic [13:0] a;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int r = 3; r < 6; r++) begin
         point(7'(r));
         rd();
      end
      for (int k = 0; k < 9; k++) begin
         s = {2'(k / 3), 2'(k % 3)};
         a = (k % 3 == 2) ? 14'h0ffc : 14'h3ffe;
         setup(s, a, 1'b0);
         for (int b = 0; b < 6; b++) wr(rnd[15:8]);
         point(7'h05);
         rd();
         setup(s, a, 1'b1);
         for (int b = 0; b < 6; b++) rd();
      end
      hold = 60;
      setup(4'h1, 14'h0010, 1'b0);
      for (int b = 0; b < 20; b++) wr(rnd[7:0]);
      check(35'(lowseen > 0), 35'h0_0000_0001);
      setup(4'h3, 14'h0005, 1'b0);
      wr(8'h5a);
      wr(8'ha5);
      rd();
      setup(4'hc, 14'h0005, 1'b1);
      rd();
      point(7'h05);
      rd();
      setup(4'h6, 14'h0020, 1'b0);
      wr(8'h77);
      setup(4'h6, 14'h0020, 1'b0);
      wr(8'h12);
      wr(8'h34);
      setup(4'h6, 14'h0020, 1'b1);
      rd();
      rd();
      point(7'h02);
      wr(8'hff);
      rd();
      point(7'h7f);
      rd();
      repeat (200) @(posedge clk);
      check(35'(exp_q.size()), 35'h0_0000_0000);
      finish_test();
   end
endmodule // indexed_table_port_tb_top

// file: sim/itp_mem_model.sv
`timescale 1ns/1ns
// ****
// Table memory model
// ****
module itp_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Requests
   input wire logic mem_req_valid,
   output logic mem_req_ready,
   input wire logic mem_req_write,
   input wire logic [1:0] mem_req_type,
   input wire logic [1:0] mem_req_colour,
   input wire logic [13:0] mem_req_addr,
   input wire logic [15:0] mem_req_wdata,
   // Pacing
   input wire logic stall,
   input wire logic [3:0] delay,
   // Answers
   output logic mem_rsp_valid,
   output logic [15:0] mem_rsp_data
);
   logic [15:0] mem [bit [17:0]];
   logic [15:0] held_ff;
   logic [17:0] key;
   int wait_ff;
   assign key = {mem_req_type, mem_req_colour, mem_req_addr};
   assign mem_req_ready = !stall && wait_ff < 0;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wait_ff <= -1;
         mem_rsp_valid <= 1'b0;
         mem_rsp_data <= 16'h0000;
      end else begin
         mem_rsp_valid <= wait_ff == 0;
         mem_rsp_data <= (wait_ff == 0) ? held_ff : ~mem_rsp_data;
         if (wait_ff >= 0) wait_ff <= wait_ff - 1;
         if (mem_req_valid && mem_req_ready && mem_req_write) mem[key] = mem_req_wdata;
         if (mem_req_valid && mem_req_ready && !mem_req_write) begin
            held_ff <= mem.exists(key) ? mem[key] : 16'h0000;
            wait_ff <= int'(delay);
         end
      end
   end
endmodule // itp_mem_model

// file: sim/itp_table_port_properties.sv
`timescale 1ns/1ns
// ****
// Table port checker
// ****
module itp_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register side
   input wire logic cfg_addr_we,
   input wire logic [6:0] cfg_addr,
   input wire logic cfg_data_we,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_data_re,
   input wire logic cfg_ready,
   input wire logic cfg_rvalid,
   input wire logic [7:0] cfg_rdata,
   // Memory side
   input wire logic mem_req_valid,
   input wire logic mem_req_write,
   input wire logic [1:0] mem_req_type,
   input wire logic [1:0] mem_req_colour,
   input wire logic [13:0] mem_req_addr,
   input wire logic [15:0] mem_req_wdata
);
   logic [6:0] ptr_ff;
   logic [3:0] sel_ff;
   logic dir_ff;
   logic phase_ff;
   logic sel_ok;
   assign sel_ok = sel_ff[1:0] != 2'h3 && sel_ff[3:2] != 2'h3;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ptr_ff <= 7'h00;
      end else if (cfg_addr_we) begin
         ptr_ff <= cfg_addr;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_ff <= 4'h0;
         dir_ff <= 1'b0;
         phase_ff <= 1'b0;
      end else if (cfg_data_we && cfg_ready) begin
         if (ptr_ff == 7'h03) sel_ff <= cfg_wdata[3:0];
         if (ptr_ff == 7'h04) dir_ff <= cfg_wdata[6];
         if (ptr_ff inside {[7'h03:7'h05]}) phase_ff <= 1'b0;
         if (ptr_ff == 7'h06 && sel_ok && !dir_ff) phase_ff <= !phase_ff;
      end
   end
   // ****
   // Properties
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_rd_taken;
      cfg_data_re && cfg_ready;
   endsequence
   sequence s_wr6;
      cfg_data_we && cfg_ready && ptr_ff == 7'h06 && sel_ok && !dir_ff;
   endsequence
   sequence s_rd_sel;
      s_rd_taken ##0 ptr_ff == 7'h03;
   endsequence
   sequence s_rd_unmapped;
      s_rd_taken ##0 !(ptr_ff inside {[7'h03:7'h06]});
   endsequence
   sequence s_addr_lo_rd;
      cfg_data_we && cfg_ready && ptr_ff == 7'h05 && sel_ok && dir_ff;
   endsequence
   sequence s_gamma_wr;
      mem_req_valid && mem_req_write && mem_req_type == 2'h2;
   endsequence
   a_select_readback: assert property (s_rd_sel |=> cfg_rvalid && cfg_rdata == {4'h0, sel_ff})
      else $error("select read back wrong");
   a_unmapped_zero: assert property (s_rd_unmapped |=> cfg_rvalid && cfg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_first_held: assert property (s_wr6 ##0 !phase_ff && !mem_req_valid |=> !mem_req_valid)
      else $error("first byte committed alone");
   a_word_commit: assert property (s_wr6 ##0 phase_ff |=> mem_req_valid)
      else $error("second byte gave no request");
   a_prefetch_issue: assert property (s_addr_lo_rd |-> ##[1:60] mem_req_valid && !mem_req_write)
      else $error("no prefetch after address set");
   a_gamma_high_zero: assert property (s_gamma_wr |-> mem_req_wdata[15:12] == 4'h0)
      else $error("gamma word upper bits set");
   a_gamma_range: assert property (mem_req_valid && mem_req_type == 2'h2 |-> mem_req_addr <= 14'h0ffd)
      else $error("gamma address out of range");
   a_known_target: assert property (mem_req_valid |-> mem_req_type != 2'h3 && mem_req_colour != 2'h3)
      else $error("request to undefined table");
endmodule // itp_checker
bind itp_table_port itp_checker chk (.clk, .rstn, .cfg_addr_we, .cfg_addr, .cfg_data_we, .cfg_wdata, .cfg_data_re,
   .cfg_ready, .cfg_rvalid, .cfg_rdata, .mem_req_valid, .mem_req_write, .mem_req_type, .mem_req_colour,
   .mem_req_addr, .mem_req_wdata);
